// *** hw/eba_dsp.sv ***
// Functional notes
// - assert host grant to hand over bus
// - hold host grant until request released
// - only bus master drives host grant
// - host grant floats one cycle first
// - host selects device with chip select
// - drive acknowledge low for host wait
// - external devices request dma on two lines
// - dma grant means transfer starts next
// - only bus owner drives dma grants
// - id picks own request line
// - single system straps id 000 or 001; code treats only 000 as single, 001 is master only after winning line 1
// - id changes only under reset
// - drive own line, monitor other five
// - rotating priority when select high
// - fixed priority when select low
// - priority select equal on all processors
// - priority access stops master background dma
// - host requests bus with request line
// - master floats bus when host granted
// - host request beats processor requests
`timescale 1ns/1ns
`default_nettype none

module eba_dsp (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // pin side
    eba_if.dev              pins,
    // user side: core needs the external bus
    input  wire logic       core_req,
    input  wire logic       dma_bg_req,
    input  wire logic       pa_request,
    // user side: slave host access finished
    input  wire logic       slave_access_done,
    // user side: internal dma channels ready (a, b)
    input  wire logic [1:0] dma_ch_ready,
    // user side: state
    output logic            is_master,
    output logic            host_owns_bus,
    output logic            bus_release,
    output logic [1:0]      dma_start,
    output logic [2:0]      own_id
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    eba_pkg::eba_host_state_e hst_r;
    eba_pkg::eba_host_state_e hst_nxt;

    logic [2:0] id_r;
    logic [2:0] owner_r;
    logic       owner_vld_r;
    logic [2:0] winner;
    logic [5:0] br_act;
    logic       hbr_act;
    logic       pa_act;
    logic       single;
    logic       master;
    logic       want_bus;
    logic       dma_ok;
    logic [1:0] dma_req_act;
    logic [1:0] gnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // winner search over the active request lines
    function automatic logic [2:0] eba_pick(
        input logic [5:0] act,
        input logic       rot,
        input logic [2:0] last
    );
        logic [2:0] w;
        logic       found;
        logic [2:0] idx;
        w     = 3'h0;
        found = 1'b0;
        idx   = 3'h0;
        for (int i = 0; i < eba_pkg::NUM_BR; i++) begin
            if (rot) begin
                idx = 3'((int'(last) + 1 + i) % eba_pkg::NUM_BR);
            end else begin
                idx = 3'(i);
            end
            if (!found && act[idx]) begin
                w     = idx;
                found = 1'b1;
            end
        end
        return w;
    endfunction : eba_pick

    ////////////////////////////////////////////////////////////////////////////
    // strap capture: id follows the pins only while reset is held
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            id_r <= pins.processor_id_straps;
        end
    end

    // decoded pin levels
    assign br_act      = ~pins.mp_arbitration_requests_n;
    assign hbr_act     = ~pins.host_bus_request_n;
    assign pa_act      = ~pins.priority_access_n;
    assign single      = (id_r == eba_pkg::ID_SINGLE);
    assign master      = single | (owner_vld_r & (owner_r == 3'(id_r - 3'h1)));
    assign winner      = eba_pick(br_act, pins.rotating_priority_select, owner_r);
    assign dma_req_act = {~pins.ext_dma_req_line_b_n, ~pins.ext_dma_req_line_a_n};

    // a slave's priority access makes the master drop background dma
    assign want_bus = core_req | (dma_bg_req & ~(master & pa_act));
    assign dma_ok   = master & (hst_r == eba_pkg::EBA_HS_IDLE) & ~pa_act;

    ////////////////////////////////////////////////////////////////////////////
    // own request line: driven only when the id selects it
    for (genvar g = 0; g < eba_pkg::NUM_BR; g++) begin : g_br
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                pins.mp_arbitration_requests_dev_o[g]    <= eba_pkg::RST_PIN;
                pins.mp_arbitration_requests_dev_oe_n[g] <= eba_pkg::RST_PIN;
            end else begin
                pins.mp_arbitration_requests_dev_o[g]    <= ~want_bus;
                pins.mp_arbitration_requests_dev_oe_n[g] <= (id_r != 3'(g + 1));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // distributed ownership, frozen while the host holds or is taking the bus
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            owner_r     <= eba_pkg::RST_OWNER;
            owner_vld_r <= 1'b0;
        end else if (hst_r == eba_pkg::EBA_HS_IDLE && !hbr_act) begin
            if (owner_vld_r && br_act[owner_r]) begin
                owner_r <= owner_r;
            end else if (|br_act) begin
                owner_r     <= winner;
                owner_vld_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host handover: idle, one float cycle, then grant until released
    always_comb begin
        hst_nxt = hst_r;
        unique case (hst_r)
            eba_pkg::EBA_HS_IDLE: begin
                if (hbr_act) begin
                    hst_nxt = eba_pkg::EBA_HS_FLOAT;
                end
            end
            eba_pkg::EBA_HS_FLOAT: begin
                if (hbr_act) begin
                    hst_nxt = eba_pkg::EBA_HS_GRANT;
                end else begin
                    hst_nxt = eba_pkg::EBA_HS_IDLE;
                end
            end
            eba_pkg::EBA_HS_GRANT: begin
                if (!hbr_act) begin
                    hst_nxt = eba_pkg::EBA_HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hst_r <= eba_pkg::EBA_HS_IDLE;
        end else begin
            hst_r <= hst_nxt;
        end
    end

    // host grant pin: only the master drives, never in the float cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.host_bus_grant_o    <= eba_pkg::RST_PIN;
            pins.host_bus_grant_oe_n <= eba_pkg::RST_PIN;
        end else begin
            pins.host_bus_grant_o    <= (hst_nxt != eba_pkg::EBA_HS_GRANT);
            pins.host_bus_grant_oe_n <= ~master | (hst_nxt == eba_pkg::EBA_HS_FLOAT);
        end
    end

    // core status: master floats its bus lines once the host takes over
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            is_master     <= 1'b0;
            host_owns_bus <= 1'b0;
            bus_release   <= 1'b0;
            own_id        <= eba_pkg::RST_ID;
        end else begin
            is_master     <= master;
            host_owns_bus <= (hst_nxt == eba_pkg::EBA_HS_GRANT);
            bus_release   <= ~master | (hst_nxt != eba_pkg::EBA_HS_IDLE);
            own_id        <= id_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host acknowledge: pull low while a selected host access is pending
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.host_wait_ack_o    <= 1'b0;
            pins.host_wait_ack_oe_n <= eba_pkg::RST_PIN;
        end else begin
            pins.host_wait_ack_o    <= 1'b0;
            pins.host_wait_ack_oe_n <= ~(~pins.chip_select_n & hbr_act & ~slave_access_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dma grants: one-cycle pulse, no grant on a channel in the cycle after its own grant
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gnt_r <= 2'h0;
        end else begin
            gnt_r <= dma_req_act & dma_ch_ready & ~gnt_r & {2{dma_ok}};
        end
    end

    // grant pins driven by the owner only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.ext_dma_grant_line_a_oe_n <= eba_pkg::RST_PIN;
            pins.ext_dma_grant_line_b_oe_n <= eba_pkg::RST_PIN;
        end else begin
            pins.ext_dma_grant_line_a_oe_n <= ~master;
            pins.ext_dma_grant_line_b_oe_n <= ~master;
        end
    end
    assign pins.ext_dma_grant_line_a_o = ~gnt_r[0];
    assign pins.ext_dma_grant_line_b_o = ~gnt_r[1];

    // transfer start, one cycle after its grant
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dma_start <= 2'h0;
        end else begin
            dma_start <= gnt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // priority access: a slave that needs the bus pulls the shared line
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.priority_access_dev_o    <= 1'b0;
            pins.priority_access_dev_oe_n <= eba_pkg::RST_PIN;
        end else begin
            pins.priority_access_dev_o    <= 1'b0;
            pins.priority_access_dev_oe_n <= ~(pa_request & ~master);
        end
    end

endmodule : eba_dsp

`default_nettype wire

// *** hw/eba_pkg.sv ***
package eba_pkg;

    // bus request lines and id strap width
    localparam int NUM_BR   = 6;
    localparam int ID_W     = 3;

    // strap value that marks a single-processor system
    localparam logic [2:0] ID_SINGLE = 3'h0;

    // number of dma handshake channels (a serves 11, b serves 12)
    localparam int NUM_DMA  = 2;
    localparam int DMA_CH_A = 11;
    localparam int DMA_CH_B = 12;

    // cycles the host grant floats before it is given
    localparam int HBG_FLOAT_CYCLES = 1;

    // reset values
    localparam logic [2:0] RST_ID    = 3'h0;
    localparam logic [2:0] RST_OWNER = 3'h0;
    localparam logic       RST_PIN   = 1'b1;

    // host side of the arbitration, as seen by every processor
    typedef enum {
        EBA_HS_IDLE,
        EBA_HS_FLOAT,
        EBA_HS_GRANT
    } eba_host_state_e;

endpackage : eba_pkg

// *** hw/eba_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface eba_if;

    // host driven pins
    logic                 host_bus_request_n;
    logic                 chip_select_n;
    logic                 ext_dma_req_line_a_n;
    logic                 ext_dma_req_line_b_n;
    logic                 rotating_priority_select;
    logic [2:0]           processor_id_straps;

    // host grant, two-way, pulled up
    logic                 host_bus_grant_o;
    logic                 host_bus_grant_oe_n;
    logic                 host_bus_grant_n;

    // host acknowledge, open drain, pulled up
    logic                 host_wait_ack_o;
    logic                 host_wait_ack_oe_n;
    logic                 host_wait_ack;

    // dma grants, pulled up
    logic                 ext_dma_grant_line_a_o;
    logic                 ext_dma_grant_line_a_oe_n;
    logic                 ext_dma_grant_line_a_n;
    logic                 ext_dma_grant_line_b_o;
    logic                 ext_dma_grant_line_b_oe_n;
    logic                 ext_dma_grant_line_b_n;

    // bus request lines, device and peers
    logic [5:0]           mp_arbitration_requests_dev_o;
    logic [5:0]           mp_arbitration_requests_dev_oe_n;
    logic [5:0]           mp_arbitration_requests_peer_o;
    logic [5:0]           mp_arbitration_requests_peer_oe_n;
    logic [5:0]           mp_arbitration_requests_n;

    // priority access, wired low
    logic                 priority_access_dev_o;
    logic                 priority_access_dev_oe_n;
    logic                 priority_access_peer_o;
    logic                 priority_access_peer_oe_n;
    logic                 priority_access_n;

    // wire levels: undriven reads high
    assign host_bus_grant_n       = host_bus_grant_oe_n ? 1'b1 : host_bus_grant_o;
    assign host_wait_ack          = host_wait_ack_oe_n ? 1'b1 : host_wait_ack_o;
    assign ext_dma_grant_line_a_n = ext_dma_grant_line_a_oe_n ? 1'b1 : ext_dma_grant_line_a_o;
    assign ext_dma_grant_line_b_n = ext_dma_grant_line_b_oe_n ? 1'b1 : ext_dma_grant_line_b_o;
    assign mp_arbitration_requests_n =
        (mp_arbitration_requests_dev_oe_n | mp_arbitration_requests_dev_o) &
        (mp_arbitration_requests_peer_oe_n | mp_arbitration_requests_peer_o);
    assign priority_access_n =
        (priority_access_dev_oe_n | priority_access_dev_o) &
        (priority_access_peer_oe_n | priority_access_peer_o);

    modport dev (
        input  host_bus_request_n, chip_select_n, ext_dma_req_line_a_n,
        input  ext_dma_req_line_b_n, rotating_priority_select, processor_id_straps,
        input  mp_arbitration_requests_n, priority_access_n,
        output host_bus_grant_o, host_bus_grant_oe_n,
        output host_wait_ack_o, host_wait_ack_oe_n,
        output ext_dma_grant_line_a_o, ext_dma_grant_line_a_oe_n,
        output ext_dma_grant_line_b_o, ext_dma_grant_line_b_oe_n,
        output mp_arbitration_requests_dev_o, mp_arbitration_requests_dev_oe_n,
        output priority_access_dev_o, priority_access_dev_oe_n
    );

    modport host (
        output host_bus_request_n, chip_select_n, ext_dma_req_line_a_n,
        output ext_dma_req_line_b_n, rotating_priority_select, processor_id_straps,
        output mp_arbitration_requests_peer_o, mp_arbitration_requests_peer_oe_n,
        output priority_access_peer_o, priority_access_peer_oe_n,
        input  host_bus_grant_n, host_wait_ack,
        input  ext_dma_grant_line_a_n, ext_dma_grant_line_b_n,
        input  mp_arbitration_requests_n, priority_access_n
    );

endinterface : eba_if

`default_nettype wire

// *** hw/eba_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module eba_host (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // pin side
    eba_if.host             pins,
    // user side: host requests
    input  wire logic       host_want_bus,
    input  wire logic       host_access,
    // user side: external port dma requests
    input  wire logic [1:0] dma_want,
    // user side: system configuration
    input  wire logic [2:0] id_strap,
    input  wire logic       rotating_priority_select_level,
    // user side: peer processors
    input  wire logic [5:0] peer_req,
    input  wire logic [5:0] peer_req_en,
    input  wire logic       peer_pa,
    // user side: observed state
    output logic            host_granted,
    output logic            host_waiting,
    output logic [1:0]      dma_granted
);

    logic [1:0] dma_req_r;

    ////////////////////////////////////////////////////////////////////////////
    // host request and chip select, held as long as the user asks
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.host_bus_request_n <= eba_pkg::RST_PIN;
            pins.chip_select_n      <= eba_pkg::RST_PIN;
        end else begin
            pins.host_bus_request_n <= ~host_want_bus;
            pins.chip_select_n      <= ~host_access;
        end
    end

    // dma request lines: drop a request once its grant is seen
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dma_req_r <= 2'h0;
        end else begin
            dma_req_r[0] <= dma_want[0] & ~(dma_req_r[0] & ~pins.ext_dma_grant_line_a_n);
            dma_req_r[1] <= dma_want[1] & ~(dma_req_r[1] & ~pins.ext_dma_grant_line_b_n);
        end
    end
    assign pins.ext_dma_req_line_a_n = ~dma_req_r[0];
    assign pins.ext_dma_req_line_b_n = ~dma_req_r[1];

    // configuration straps, changed only under reset; rotating_priority_select goes to all at once
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.processor_id_straps <= id_strap;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.rotating_priority_select <= 1'b0;
        end else begin
            pins.rotating_priority_select <= rotating_priority_select_level;
        end
    end

    // peer processors: each drives only its enabled line
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins.mp_arbitration_requests_peer_o    <= 6'h3f;
            pins.mp_arbitration_requests_peer_oe_n <= 6'h3f;
            pins.priority_access_peer_o            <= eba_pkg::RST_PIN;
            pins.priority_access_peer_oe_n         <= eba_pkg::RST_PIN;
        end else begin
            pins.mp_arbitration_requests_peer_o    <= ~peer_req;
            pins.mp_arbitration_requests_peer_oe_n <= ~peer_req_en;
            pins.priority_access_peer_o            <= 1'b0;
            pins.priority_access_peer_oe_n         <= ~peer_pa;
        end
    end

    // observed state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            host_granted <= 1'b0;
            host_waiting <= 1'b0;
            dma_granted  <= 2'h0;
        end else begin
            host_granted <= ~pins.host_bus_grant_n & ~pins.host_bus_request_n;
            host_waiting <= ~pins.host_wait_ack;
            dma_granted  <= {~pins.ext_dma_grant_line_b_n, ~pins.ext_dma_grant_line_a_n};
        end
    end

endmodule : eba_host

`default_nettype wire

// *** tb/eba_check_sva.sv ***
`timescale 1ns/1ns
`default_nettype none

module eba_check (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // host pins
    input wire logic       host_bus_request_n,
    input wire logic       chip_select_n,
    input wire logic       host_bus_grant_n,
    input wire logic       host_bus_grant_oe_n,
    input wire logic       host_wait_ack,
    // dma and priority pins
    input wire logic       ext_dma_req_line_a_n,
    input wire logic       ext_dma_grant_line_a_n,
    input wire logic       ext_dma_grant_line_b_n,
    input wire logic       priority_access_n,
    // arbitration pins
    input wire logic [2:0] processor_id_straps,
    input wire logic [5:0] mp_arbitration_requests_dev_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // the one request line the strap lets this device drive
    logic [5:0] own_mask;
    assign own_mask = (processor_id_straps == 3'h0) ? 6'h00 :
                      6'h01 << (processor_id_straps - 3'h1);

    // host request seen, then held through float and grant
    sequence s_req_seen;
        $fell(host_bus_request_n);
    endsequence
    sequence s_req_held;
        !host_bus_request_n [*2];
    endsequence

    AST_HBG_FLOAT: assert property (s_req_seen |=> host_bus_grant_oe_n)
        else $error("host grant driven in float cycle");
    AST_HBG_GIVEN: assert property ((processor_id_straps == 3'h0) ##0 s_req_seen ##1 s_req_held
        |-> !host_bus_grant_n && !host_bus_grant_oe_n)
        else $error("host grant not given two cycles after request");
    AST_HBG_HOLD: assert property (!host_bus_grant_n && !host_bus_request_n |=> !host_bus_grant_n)
        else $error("host grant dropped while request held");
    AST_HBG_RELEASE: assert property (!host_bus_grant_n && host_bus_request_n |=> host_bus_grant_n)
        else $error("host grant kept after request released");
    AST_ACK_CAUSE: assert property (!host_wait_ack |-> $past(!chip_select_n && !host_bus_request_n))
        else $error("wait acknowledge low without select and request");
    AST_ACK_RELEASE: assert property ($rose(host_bus_request_n) || $rose(chip_select_n)
        |=> host_wait_ack)
        else $error("wait acknowledge held after access ended");
    AST_DMA_PULSE: assert property (!ext_dma_grant_line_a_n |=> ext_dma_grant_line_a_n)
        else $error("dma grant a longer than one cycle");
    AST_DMA_CAUSE: assert property (!ext_dma_grant_line_a_n |-> $past(!ext_dma_req_line_a_n))
        else $error("dma grant a without request");
    AST_DMA_PA: assert property (!priority_access_n
        |=> ext_dma_grant_line_a_n && ext_dma_grant_line_b_n)
        else $error("dma grant during priority access");
    AST_DMA_HOST: assert property (!host_bus_grant_n
        |-> ext_dma_grant_line_a_n && ext_dma_grant_line_b_n)
        else $error("dma grant while host owns bus");
    AST_OWN_LINE: assert property ((~mp_arbitration_requests_dev_oe_n & ~own_mask) == 6'h00)
        else $error("request line of another id driven");

endmodule : eba_check

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none

module testbench;
    // clock, reset and counters
    logic       clock;
    logic       rst_n;
    int         num_errors;
    int         total_checks;
    // host user side
    logic       host_want_bus;
    logic       host_access;
    logic [1:0] dma_want;
    logic [2:0] id_strap;
    logic       rotating_priority_select_level;
    logic [5:0] peer_req;
    logic       peer_pa;
    logic       host_granted;
    logic       host_waiting;
    logic [1:0] dma_granted;
    // device user side
    logic       core_req, bg_req;
    logic       slave_access_done;
    logic [1:0] dma_ch_ready;
    logic       is_master;
    logic       host_owns_bus;
    logic       bus_release;
    logic [1:0] dma_start;
    logic [2:0] own_id;

    eba_if pins ();

    // the two ends and the checker on the shared pins
    eba_host i_eba_host (.clock(clock), .rst_n(rst_n), .pins(pins),
        .host_want_bus(host_want_bus), .host_access(host_access), .dma_want(dma_want),
        .id_strap(id_strap), .rotating_priority_select_level(rotating_priority_select_level), .peer_req(peer_req),
        .peer_req_en(peer_req), .peer_pa(peer_pa), .host_granted(host_granted),
        .host_waiting(host_waiting), .dma_granted(dma_granted));
    eba_dsp i_eba_dsp (.clock(clock), .rst_n(rst_n), .pins(pins), .core_req(core_req),
        .dma_bg_req(bg_req), .pa_request(1'b0), .slave_access_done(slave_access_done),
        .dma_ch_ready(dma_ch_ready), .is_master(is_master), .host_owns_bus(host_owns_bus),
        .bus_release(bus_release), .dma_start(dma_start), .own_id(own_id));
    eba_check i_eba_check (.clock(clock), .rst_n(rst_n),
        .host_bus_request_n(pins.host_bus_request_n), .chip_select_n(pins.chip_select_n),
        .host_bus_grant_n(pins.host_bus_grant_n),
        .host_bus_grant_oe_n(pins.host_bus_grant_oe_n), .host_wait_ack(pins.host_wait_ack),
        .ext_dma_req_line_a_n(pins.ext_dma_req_line_a_n),
        .ext_dma_grant_line_a_n(pins.ext_dma_grant_line_a_n),
        .ext_dma_grant_line_b_n(pins.ext_dma_grant_line_b_n),
        .priority_access_n(pins.priority_access_n),
        .processor_id_straps(pins.processor_id_straps),
        .mp_arbitration_requests_dev_oe_n(pins.mp_arbitration_requests_dev_oe_n));

    // 10 MHz clock
    always #50 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // step past edges, then drive and sample settled values
    task automatic step(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic chk_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_vec(input string name, input logic [5:0] exp, input logic [5:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_vec

    function automatic logic dma_gnt(input int ch);
        return ch ? pins.ext_dma_grant_line_b_n : pins.ext_dma_grant_line_a_n;
    endfunction : dma_gnt

    task automatic do_reset(input logic [2:0] id);
        rst_n = 1'b0;
        id_strap = id;
        step(12);
        rst_n = 1'b1;
        step();
    endtask : do_reset

    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////////////////
    // host takes the bus: float, grant, hold, give back
    task automatic t_host();
        int n;
        host_want_bus = 1'b1;
        for (n = 0; n < 10 && pins.host_bus_request_n !== 1'b0; n++) step();
        step();
        chk_bit("grant float", 1'b1, pins.host_bus_grant_oe_n);
        chk_bit("grant level in float", 1'b1, pins.host_bus_grant_n);
        step();
        chk_bit("grant given", 1'b0, pins.host_bus_grant_n);
        step(3);
        chk_bit("grant held", 1'b0, pins.host_bus_grant_n);
        chk_bit("bus floated", 1'b1, bus_release);
        chk_bit("host granted", 1'b1, host_granted);
        host_want_bus = 1'b0;
        for (n = 0; n < 10 && pins.host_bus_request_n !== 1'b1; n++) step();
        step();
        chk_bit("grant returned", 1'b1, pins.host_bus_grant_n);
        chk_bit("grant driven by master", 1'b0, pins.host_bus_grant_oe_n);
        step();
        chk_bit("bus retaken", 1'b0, bus_release);
    endtask : t_host

    // asynchronous host access held off by the acknowledge
    task automatic t_wait();
        int n;
        host_want_bus = 1'b1;
        host_access = 1'b1;
        for (n = 0; n < 10 && pins.host_wait_ack !== 1'b0; n++) step();
        chk_bit("ack wait", 1'b0, pins.host_wait_ack);
        step(2);
        chk_bit("ack held", 1'b0, pins.host_wait_ack);
        chk_bit("host waits", 1'b1, host_waiting);
        slave_access_done = 1'b1;
        step(2);
        chk_bit("ack freed", 1'b1, pins.host_wait_ack);
        host_access = 1'b0;
        host_want_bus = 1'b0;
        slave_access_done = 1'b0;
        step(4);
    endtask : t_wait

    // both dma channels, then a priority access hold-off
    task automatic t_dma();
        int n;
        dma_ch_ready = 2'b11;
        for (int ch = 0; ch < 2; ch++) begin
            dma_want = 2'b01 << ch;
            for (n = 0; n < 10 && dma_gnt(ch) !== 1'b0; n++) step();
            chk_bit("dma grant", 1'b0, dma_gnt(ch));
            step();
            chk_bit("dma grant pulse", 1'b1, dma_gnt(ch));
            chk_bit("dma start", 1'b1, dma_start[ch]);
            dma_want = 2'b00;
            step(3);
        end
        peer_pa = 1'b1;
        dma_want = 2'b11;
        step(2);
        for (n = 0; n < 8; n++) begin
            chk_bit("dma held off", 1'b1, dma_gnt(0) & dma_gnt(1));
            step();
        end
        peer_pa = 1'b0;
        for (n = 0; n < 10 && (dma_gnt(0) & dma_gnt(1)) !== 1'b0; n++) step();
        chk_bit("dma after access", 1'b0, dma_gnt(0) & dma_gnt(1));
        dma_want = 2'b00;
        step(4);
    endtask : t_dma

    // id 2 arbitrates against lines 3 and 4 under one priority scheme
    task automatic t_arb(input logic rot);
        rotating_priority_select_level = rot;
        core_req = 1'b0;
        peer_req = 6'h04;
        step(5);
        core_req = 1'b1;
        peer_req = 6'h0c;
        step(4);
        chk_bit("holder kept", 1'b0, is_master);
        chk_vec("own line", 6'h3d, pins.mp_arbitration_requests_dev_oe_n);
        peer_req = 6'h08;
        step(4);
        chk_bit("next owner", !rot, is_master);
        peer_req = 6'h00;
        step(4);
        chk_bit("free bus taken", 1'b1, is_master);
        {core_req, bg_req, peer_pa} = 3'h3;
        step(2);
        chk_bit("bg drop", 1'b1, pins.mp_arbitration_requests_n[1]);
        {bg_req, peer_pa} = 2'h0;
    endtask : t_arb

    // host beats a waiting processor line
    task automatic t_prec();
        int n;
        peer_req = 6'h08;
        host_want_bus = 1'b1;
        for (n = 0; n < 10 && host_granted !== 1'b1; n++) step();
        chk_bit("host first", 1'b1, host_owns_bus);
        host_want_bus = 1'b0;
        peer_req = 6'h00;
        step(4);
    endtask : t_prec

    ////////////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clock = 1'b0;
        num_errors = 0;
        total_checks = 0;
        {host_want_bus, host_access, dma_want, rotating_priority_select_level, peer_req, peer_pa} = '0;
        {core_req, bg_req, slave_access_done, dma_ch_ready} = '0;
        do_reset(3'h0);
        t_host();
        t_wait();
        t_dma();
        do_reset(3'h2);
        chk_vec("own id", 6'h02, {3'h0, own_id});
        t_arb(1'b0);
        t_arb(1'b1);
        t_prec();
        test_done();
    end

    // watchdog
    initial begin
        #2000000;
        num_errors++;
        test_done();
    end

endmodule : testbench

`default_nettype wire
